/* File: dv/eic_bridge_model.sv */
module eic_bridge_model (
	input  wire logic  i_clk,
	output logic       o_cmd_valid,
	output logic [7:0] o_cmd_code,
	output logic [7:0] o_cmd_type,
	output logic [7:0] o_cmd_len,
	output logic       o_wr_valid,
	output logic [7:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code  = 8'h00;
		o_cmd_type  = 8'h00;
		o_cmd_len   = 8'h00;
		o_wr_valid  = 1'b0;
		o_wr_data   = 8'h00;
	end
	// attention command: one-cycle strobe, code and type scrambled afterwards, length left as sent
	task automatic send_cmd(input logic [7:0] code, input logic [7:0] typ, input logic [7:0] len);
		@(posedge i_clk);
		#2;
		o_cmd_valid = 1'b1;
		o_cmd_code  = code;
		o_cmd_type  = typ;
		o_cmd_len   = len;
		@(posedge i_clk);
		#2;
		o_cmd_valid = 1'b0;
		o_cmd_code  = ~code;
		o_cmd_type  = ~typ;
	endtask : send_cmd
	// caller sits just after an edge; byte is taken at the next edge
	task automatic send_byte(input logic [7:0] b);
		o_wr_valid = 1'b1;
		o_wr_data  = b;
		@(posedge i_clk);
		#2;
	endtask : send_byte
	task automatic idle();
		o_wr_valid = 1'b0;
		o_wr_data  = ~o_wr_data;
	endtask : idle
endmodule : eic_bridge_model

/* File: dv/enclosure_identify_and_activity_ctrl_tb_top.sv */
module enclosure_identify_and_activity_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import eic_pkg::*;
	localparam int           BLK = 200;
	localparam logic [7:0]   WR_CODE = 8'h10;
	localparam logic [63:0]  LID = 64'h5a1b2c3d4e5f6071; // arbitrary value
	localparam logic [63:0]  VND = 64'h424f58574f524b53;
	localparam logic [127:0] PRD = 128'h5348454c462020202020202020202020;
	localparam logic [31:0]  PRV = 32'h30313030;
	localparam logic [31:0]  FWR = 32'h30323031;
	localparam logic [31:0]  IFR = 32'h312e3030;
	logic clk, rst_n, cv, wv, busy, rdv, done;
	logic [7:0] chan, cc, ct, cl, wd, rdd, st;
	logic [3:0] flag, led;
	logic [7:0] rxq[$];
	logic [7:0] wb[$];
	logic [31:0] seed;
	int error_cnt, num_checks, cyc, take_c, first_c, last_c, done_c;
	eic_bridge_model i_eic_bridge_model (.i_clk(clk), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_type(ct),
		.o_cmd_len(cl), .o_wr_valid(wv), .o_wr_data(wd));
	eic_ctrl #(.LOGICAL_ID(LID), .VENDOR_STR(VND), .PRODUCT_STR(PRD), .PREV_STR(PRV), .FWREV_STR(FWR),
		.IFREV_STR(IFR), .SUPPORT_SAFTE(1'b1), .SUPPORT_SES(1'b1), .BLINK_DUR(BLK)) i_eic_ctrl (
		.i_clk(clk), .i_resetn(rst_n), .i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_type(ct), .i_cmd_len(cl),
		.i_channel_id(chan), .i_wr_valid(wv), .i_wr_data(wd), .o_busy(busy), .o_rd_valid(rdv),
		.o_rd_data(rdd), .o_done(done), .o_status(st), .o_act_flag(flag), .o_act_led(led));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cv === 1'b1 && busy === 1'b0) take_c = cyc;
		if (rdv === 1'b1) begin
			rxq.push_back(rdd);
			if (rxq.size() == 1) first_c = cyc;
			last_c = cyc;
		end
		if (done === 1'b1) done_c = cyc;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] exp_id(int k, logic ses);
		logic [47:0] ifid;
		ifid = ses ? IFID_SES : IFID_SAFTE;
		if (k == 0) return 8'h40;
		if (k >= 2 && k <= 9) return LID[8*(9-k) +: 8];
		if (k >= 10 && k <= 17) return VND[8*(17-k) +: 8];
		if (k >= 18 && k <= 33) return PRD[8*(33-k) +: 8];
		if (k >= 34 && k <= 37) return PRV[8*(37-k) +: 8];
		if (k == 38) return chan;
		if (k >= 39 && k <= 42) return FWR[8*(42-k) +: 8];
		if (k >= 43 && k <= 48) return ifid[8*(48-k) +: 8];
		if (k >= 49 && k <= 52) return IFR[8*(52-k) +: 8];
		return 8'h00;
	endfunction : exp_id
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task automatic run(input logic [7:0] code, input logic [7:0] typ, input logic [7:0] len);
		rxq.delete();
		done_c = 0;
		i_eic_bridge_model.send_cmd(code, typ, len);
		foreach (wb[i]) i_eic_bridge_model.send_byte(wb[i]);
		i_eic_bridge_model.idle();
		for (int n = 0; n < 300 && done_c == 0; n++) @(posedge clk);
		#2;
		check(done_c != 0, 1);
	endtask : run
	task automatic ident(input logic [7:0] typ, input logic [7:0] len);
		chan = len[0] ? 8'(rnd()) : 8'h00;
		wb.delete();
		run(CMD_IDENTIFY, typ, len);
		check(rxq.size(), len);
		foreach (rxq[k]) begin
			check(rxq[k], exp_id(k, typ == TYPE_SES_RD));
			if (k inside {[10:37], [39:52]}) check(rxq[k] inside {[8'h20:8'h7e]}, 1);
		end
		check(len == 0 ? done_c - take_c : first_c - take_c, 2);
		if (len != 0) check(done_c - last_c, 1);
		check(st, STATUS_OK);
	endtask : ident
	task automatic slot_write(input int s, input logic act);
		wb.delete();
		for (int i = 0; i < 4; i++) begin
			// the whole slot is written whenever any of its flags is set
			if (i == s && act) wb = {wb, 8'(rnd()), 8'(rnd()) | 8'h04, 8'(rnd())};
			else wb = {wb, 8'h00, 8'h00, 8'h00};
		end
		run(WR_CODE, TYPE_SAFTE_WR, 8'd12);
		check(st, STATUS_OK);
	endtask : slot_write
	initial begin
		int s;
		seed = 32'd10681;
		chan = 8'h00;
		rst_n = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		#2;
		check({busy, done, flag}, 0);
		rst_n = 1'b1;
		ident(TYPE_SAFTE_RD, 8'h40);
		ident(TYPE_SES_RD, 8'h41);
		ident(TYPE_SAFTE_RD, 8'h00);
		repeat (6) ident(rnd() & 1 ? TYPE_SES_RD : TYPE_SAFTE_RD, 8'd1 + 8'(rnd() % 63));
		wb.delete();
		for (int e = 0; e < 3; e++) begin
			if (e < 2) run(8'hed + 8'(rnd() % 8'h80), TYPE_SAFTE_RD, 8'h08);
			else run(CMD_IDENTIFY, 8'h05, 8'h08);
			check(st, STATUS_ERR);
			check(done_c - take_c, 2);
			check(rxq.size(), 0);
		end
		s = rnd() % 4;
		slot_write(s, 1'b1);
		check(flag, 4'h1 << s);
		slot_write(s, 1'b0);
		check(flag, 4'h1 << s);
		repeat (BLK / 2) @(posedge clk);
		check(flag, 4'h1 << s);
		repeat (BLK) @(posedge clk);
		check({flag, led}, 0);
		s = rnd() % 4;
		wb.delete();
		repeat (8) wb.push_back(8'(rnd()));
		for (int i = 0; i < 4; i++) wb = {wb, 8'(rnd()), 8'(rnd()), i == s ? 8'(rnd()) | 8'h80 : 8'(rnd()) & 8'h7f, 8'(rnd())};
		run(WR_CODE, TYPE_SES_WR, 8'd24);
		check(st, STATUS_OK);
		check(flag, 4'h1 << s);
		repeat (BLK + 40) @(posedge clk);
		check({flag, led}, 0);
		summarize();
	end
	initial begin
		#500us;
		error_cnt++;
		summarize();
	end
endmodule : enclosure_identify_and_activity_ctrl_tb_top

/* File: logic/eic_blink.sv */
module eic_blink
	import eic_pkg::*;
#(
	parameter int DURATION = BLINK_CYC,
	parameter int HALF     = TOGGLE_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_start,
	output logic      o_active,
	output logic      o_led
);
	logic [24:0] dur_reg, dur_next;
	logic [24:0] tog_reg, tog_next;
	logic        led_reg, led_next;
	logic        act_reg, act_next;

	always_comb begin
		dur_next = dur_reg;
		tog_next = tog_reg;
		led_next = led_reg;
		act_next = act_reg;
		if (i_start) begin
			act_next = 1'b1;
			dur_next = 25'(DURATION - 1);
			tog_next = 25'(HALF - 1);
			led_next = 1'b1;
		end else if (act_reg) begin
			// blink for the duration, then clear and go dark
			if (dur_reg == 25'h0) begin
				act_next = 1'b0;
				led_next = 1'b0;
			end else begin
				dur_next = dur_reg - 25'h1;
				if (tog_reg == 25'h0) begin
					tog_next = 25'(HALF - 1);
					led_next = ~led_reg;
				end else begin
					tog_next = tog_reg - 25'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			dur_reg <= 25'h0;
			tog_reg <= 25'h0;
			led_reg <= 1'b0;
			act_reg <= 1'b0;
		end else begin
			dur_reg <= dur_next;
			tog_reg <= tog_next;
			led_reg <= led_next;
			act_reg <= act_next;
		end
	end

	assign o_active = act_reg;
	assign o_led    = led_reg;
endmodule : eic_blink

/* File: logic/eic_ctrl.sv */
// Behaviour
// - identify is command code ECh with type 00h or 02h.
// - ascii fields use only 20h..7Eh, space padded.
// - leftmost character sits at lowest byte offset.
// - reserved bytes and bits return zero.
// - only the requested number of leading bytes is returned.
// - identify structure is 64 bytes.
// - byte 0 reports the count of valid bytes.
// - sub-enclosure identifier byte reads zero.
// - logical identifier is 8 bytes with authority code 5h.
// - vendor, product and revision strings formatted as inquiry data.
// - channel identifier byte holds channel value or zero.
// - firmware revision is four ascii characters.
// - interface id returns SAF-TE or S-E-S by command type.
// - interface revision is ascii digit, period, digit, digit.
// - slot data is three bytes per slot from slot 0.
// - slot with all flags clear keeps its state.
// - ses activity flag is bit 7 of element byte 2.
// - activity flag blinks its led about 0.5 s then clears.
// - ending status 50h on success, 51h on error.
module eic_ctrl
	import eic_pkg::*;
#(
	parameter logic [63:0]  LOGICAL_ID = 64'h5000000000000001, // arbitrary value
	parameter logic [63:0]  VENDOR_STR = 64'h454e434c4f535552,
	parameter logic [127:0] PRODUCT_STR = 128'h4241434b504c414e4520202020202020,
	parameter logic [31:0]  PREV_STR   = 32'h31303030,
	parameter logic [31:0]  FWREV_STR  = 32'h30313030,
	parameter logic [31:0]  IFREV_STR  = 32'h312e3030,
	parameter logic         SUPPORT_SAFTE = 1'b1,
	parameter logic         SUPPORT_SES   = 1'b1,
	parameter int           BLINK_DUR  = BLINK_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [7:0]  i_cmd_type,
	input  wire logic [7:0]  i_cmd_len,
	input  wire logic [7:0]  i_channel_id,
	input  wire logic        i_wr_valid,
	input  wire logic [7:0]  i_wr_data,
	output logic             o_busy,
	output logic             o_rd_valid,
	output logic [7:0]       o_rd_data,
	output logic             o_done,
	output logic [7:0]       o_status,
	output logic [eic_pkg::NUM_SLOTS-1:0] o_act_flag,
	output logic [eic_pkg::NUM_SLOTS-1:0] o_act_led
);
	import eic_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10,
		ST_DONE  = 2'b11
	} eic_state_t;

	eic_state_t  state_reg, state_next;
	logic [7:0]  idx_reg, idx_next;
	logic [7:0]  len_reg, len_next;
	logic        ses_reg, ses_next;
	logic [7:0]  dat_reg, dat_next;
	logic        rdv_reg, rdv_next;
	logic        busy_reg, busy_next;
	logic        done_reg, done_next;
	logic [7:0]  stat_reg, stat_next;
	logic [7:0]  sb0_reg, sb0_next;
	logic [7:0]  sb1_reg, sb1_next;
	logic [NUM_SLOTS-1:0] start_reg, start_next;
	logic [NUM_SLOTS-1:0] act_reg, act_next;
	logic [NUM_SLOTS-1:0] led_reg, led_next;
	logic [NUM_SLOTS-1:0] blink_act, blink_led;

	// pick one byte of a string, byte 0 = leftmost character
	function automatic logic [7:0] str_byte(input logic [127:0] s, input int nbytes, input int k);
		logic [7:0] c;
		c = s[(nbytes - 1 - k) * 8 +: 8];
		if (c < ASCII_SPACE || c > ASCII_MAX)
			c = ASCII_SPACE;
		return c;
	endfunction : str_byte

	function automatic logic [7:0] id_byte(input logic [5:0] a, input logic ses, input logic [7:0] ch);
		logic [7:0] b;
		logic [63:0] lid;
		b = 8'h00;
		lid = {AUTH_IEEE, LOGICAL_ID[59:0]};
		if (a == OFS_LEN)
			b = ID_LEN;
		else if (a == OFS_SUBENC)
			b = 8'h00;
		else if (a < OFS_VENDOR)
			b = lid[(7 - int'(a - OFS_LID)) * 8 +: 8];
		else if (a < OFS_PRODUCT)
			b = str_byte({64'h0, VENDOR_STR}, 8, int'(a - OFS_VENDOR));
		else if (a < OFS_PREV)
			b = str_byte(PRODUCT_STR, 16, int'(a - OFS_PRODUCT));
		else if (a < OFS_CHANNEL)
			b = str_byte({96'h0, PREV_STR}, 4, int'(a - OFS_PREV));
		else if (a == OFS_CHANNEL)
			b = ch;
		else if (a < OFS_IFID)
			b = str_byte({96'h0, FWREV_STR}, 4, int'(a - OFS_FWREV));
		else if (a < OFS_IFREV)
			b = str_byte({80'h0, (ses ? IFID_SES : IFID_SAFTE)}, 6, int'(a - OFS_IFID));
		else if (a < OFS_VSPEC)
			b = str_byte({96'h0, IFREV_STR}, 4, int'(a - OFS_IFREV));
		return b;
	endfunction : id_byte

	// which slot a slot-status byte belongs to, and its byte within the slot
	function automatic logic [7:0] slot_of(input logic [7:0] i, input logic ses);
		logic [7:0] r;
		if (ses)
			r = (i - 8'(SES_ELEM_FIRST)) >> 2;
		else
			r = i / 8'(SLOT_BYTES);
		return r;
	endfunction : slot_of

	function automatic logic [7:0] pos_of(input logic [7:0] i, input logic ses);
		logic [7:0] r;
		if (ses)
			r = (i - 8'(SES_ELEM_FIRST)) & 8'h03;
		else
			r = i % 8'(SLOT_BYTES);
		return r;
	endfunction : pos_of

	logic       id_ok, wr_ok, type_ok;
	logic [7:0] w_slot, w_pos;

	always_comb begin
		type_ok = (i_cmd_type == TYPE_SAFTE_RD && SUPPORT_SAFTE) || (i_cmd_type == TYPE_SES_RD && SUPPORT_SES);
		id_ok   = (i_cmd_code == CMD_IDENTIFY) && type_ok;
		wr_ok   = (i_cmd_type == TYPE_SAFTE_WR && SUPPORT_SAFTE) || (i_cmd_type == TYPE_SES_WR && SUPPORT_SES);
		w_slot  = slot_of(idx_reg, ses_reg);
		w_pos   = pos_of(idx_reg, ses_reg);
	end

	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		len_next   = len_reg;
		ses_next   = ses_reg;
		dat_next   = 8'h00;
		rdv_next   = 1'b0;
		done_next  = 1'b0;
		stat_next  = stat_reg;
		sb0_next   = sb0_reg;
		sb1_next   = sb1_reg;
		start_next = '0;
		case (state_reg)
			ST_IDLE: begin
				idx_next = 8'h00;
				if (i_cmd_valid) begin
					len_next = i_cmd_len;
					ses_next = i_cmd_type[1];
					if (id_ok) begin
						state_next = (i_cmd_len == 8'h00) ? ST_DONE : ST_READ;
						stat_next  = STATUS_OK;
					end else if (wr_ok) begin
						state_next = (i_cmd_len == 8'h00) ? ST_DONE : ST_WRITE;
						stat_next  = STATUS_OK;
					end else begin
						state_next = ST_DONE;
						stat_next  = STATUS_ERR;
					end
				end
			end
			ST_READ: begin
				rdv_next = 1'b1;
				dat_next = (idx_reg < ID_LEN) ? id_byte(idx_reg[5:0], ses_reg, i_channel_id) : 8'h00;
				idx_next = idx_reg + 8'h01;
				if (idx_reg + 8'h01 == len_reg)
					state_next = ST_DONE;
			end
			ST_WRITE: begin
				if (i_wr_valid) begin
					idx_next = idx_reg + 8'h01;
					if (!ses_reg && w_slot < 8'(NUM_SLOTS)) begin
						if (w_pos == 8'h00)
							sb0_next = i_wr_data;
						else if (w_pos == 8'h01)
							sb1_next = i_wr_data;
						else if ((sb0_next | sb1_next | i_wr_data) != 8'h00)
							start_next[w_slot[1:0]] = sb1_reg[SAFTE_ACT_BIT];
					end else if (ses_reg && idx_reg >= 8'(SES_ELEM_FIRST) && w_slot < 8'(NUM_SLOTS)) begin
						if (w_pos == 8'(SES_ACT_BYTE) && i_wr_data[SES_ACT_BIT])
							start_next[w_slot[1:0]] = 1'b1;
					end
					if (idx_reg + 8'h01 == len_reg)
						state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				done_next  = 1'b1;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		busy_next = (state_next != ST_IDLE);
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
			eic_blink #(
				.DURATION (BLINK_DUR),
				.HALF     (TOGGLE_CYC)
			) u_blink (
				.i_clk    (i_clk),
				.i_resetn (i_resetn),
				.i_start  (start_reg[g]),
				.o_active (blink_act[g]),
				.o_led    (blink_led[g])
			);
		end
	endgenerate

	always_comb begin
		act_next = blink_act | start_reg;
		led_next = blink_led;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_reg <= ST_IDLE;
			idx_reg   <= 8'h00;
			len_reg   <= 8'h00;
			ses_reg   <= 1'b0;
			dat_reg   <= RESET_BYTE;
			rdv_reg   <= 1'b0;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
			stat_reg  <= RESET_BYTE;
			sb0_reg   <= 8'h00;
			sb1_reg   <= 8'h00;
			start_reg <= '0;
			act_reg   <= '0;
			led_reg   <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			len_reg   <= len_next;
			ses_reg   <= ses_next;
			dat_reg   <= dat_next;
			rdv_reg   <= rdv_next;
			busy_reg  <= busy_next;
			done_reg  <= done_next;
			stat_reg  <= stat_next;
			sb0_reg   <= sb0_next;
			sb1_reg   <= sb1_next;
			start_reg <= start_next;
			act_reg   <= act_next;
			led_reg   <= led_next;
		end
	end

	assign o_busy     = busy_reg;
	assign o_rd_valid = rdv_reg;
	assign o_rd_data  = dat_reg;
	assign o_done     = done_reg;
	assign o_status   = stat_reg;
	assign o_act_flag = act_reg;
	assign o_act_led  = led_reg;

	sequence s_ident_cmd;
		state_reg == ST_IDLE && i_cmd_valid && id_ok;
	endsequence

	sequence s_ident_read;
		state_reg == ST_IDLE && i_cmd_valid && id_ok && i_cmd_len != 8'h00;
	endsequence

	property p_id_status;
		@(posedge i_clk) disable iff (!i_resetn)
		s_ident_cmd |=> stat_reg == STATUS_OK;
	endproperty
	a_id_status: assert property (p_id_status) else $error("identify status not 50h");

	property p_bad_status;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_IDLE && i_cmd_valid && !id_ok && !wr_ok) |=> ##1 (o_done && o_status == STATUS_ERR);
	endproperty
	a_bad_status: assert property (p_bad_status) else $error("bad command not 51h");

	property p_first_byte;
		@(posedge i_clk) disable iff (!i_resetn)
		(s_ident_read ##1 1'b1) |=> (o_rd_valid && o_rd_data == ID_LEN);
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("byte 0 not length");

	property p_ascii;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_READ && idx_reg >= 8'(OFS_VENDOR) && idx_reg < 8'(OFS_CHANNEL))
			|=> (o_rd_data >= ASCII_SPACE && o_rd_data <= ASCII_MAX);
	endproperty
	a_ascii: assert property (p_ascii) else $error("non printable string byte");

	property p_reserved;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_READ && (idx_reg == 8'(OFS_SUBENC) || idx_reg >= 8'(OFS_VSPEC))) |=> o_rd_data == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved byte nonzero");

	property p_len;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_READ && idx_reg + 8'h01 == len_reg) |=> ##1 (!o_rd_valid && o_done);
	endproperty
	a_len: assert property (p_len) else $error("read ran past length");

	property p_authority;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_READ && idx_reg == 8'(OFS_LID)) |=> o_rd_data[7:4] == AUTH_IEEE;
	endproperty
	a_authority: assert property (p_authority) else $error("authority code not 5h");

	property p_blink_start;
		@(posedge i_clk) disable iff (!i_resetn)
		(start_reg != '0) |=> ((o_act_flag & $past(start_reg)) == $past(start_reg))
			##1 ((o_act_flag & o_act_led & $past(start_reg, 2)) == $past(start_reg, 2));
	endproperty
	a_blink_start: assert property (p_blink_start) else $error("activity did not start");

	property p_ifid;
		@(posedge i_clk) disable iff (!i_resetn)
		(state_reg == ST_READ && idx_reg == 8'(OFS_IFID)) |=> o_rd_data == 8'h53;
	endproperty
	a_ifid: assert property (p_ifid) else $error("interface id wrong");
endmodule : eic_ctrl

/* File: logic/eic_pkg.sv */
package eic_pkg;
	localparam logic [7:0] ATTN_OPCODE     = 8'h67;
	localparam logic [7:0] CMD_IDENTIFY    = 8'hec;
	localparam logic [7:0] TYPE_SAFTE_RD   = 8'h00;
	localparam logic [7:0] TYPE_SES_RD     = 8'h02;
	localparam logic [7:0] TYPE_SAFTE_WR   = 8'h80;
	localparam logic [7:0] TYPE_SES_WR     = 8'h82;
	localparam logic [7:0] STATUS_OK       = 8'h50;
	localparam logic [7:0] STATUS_ERR      = 8'h51;
	localparam logic [7:0] ASCII_SPACE     = 8'h20;
	localparam logic [7:0] ASCII_MAX       = 8'h7e;
	localparam logic [7:0] ID_LEN          = 8'h40;
	localparam logic [5:0] OFS_LEN         = 6'h00;
	localparam logic [5:0] OFS_SUBENC      = 6'h01;
	localparam logic [5:0] OFS_LID         = 6'h02;
	localparam logic [5:0] OFS_VENDOR      = 6'h0a;
	localparam logic [5:0] OFS_PRODUCT     = 6'h12;
	localparam logic [5:0] OFS_PREV        = 6'h22;
	localparam logic [5:0] OFS_CHANNEL     = 6'h26;
	localparam logic [5:0] OFS_FWREV       = 6'h27;
	localparam logic [5:0] OFS_IFID        = 6'h2b;
	localparam logic [5:0] OFS_IFREV       = 6'h31;
	localparam logic [5:0] OFS_VSPEC       = 6'h35;
	localparam logic [3:0] AUTH_IEEE       = 4'h5;
	localparam logic [47:0] IFID_SAFTE     = 48'h5341462d5445;
	localparam logic [47:0] IFID_SES       = 48'h532d452d5320;
	localparam int         NUM_SLOTS       = 4;
	localparam logic [2:0] SLOT_BYTES      = 3'h3;
	localparam logic [2:0] SAFTE_ACT_BIT   = 3'h2;
	localparam logic [1:0] SES_ACT_BYTE    = 2'h2;
	localparam logic [2:0] SES_ACT_BIT     = 3'h7;
	localparam logic [5:0] SES_ELEM_BYTES  = 6'h04;
	localparam logic [5:0] SES_ELEM_FIRST  = 6'h08;
	localparam int         CLK_HZ          = 40000000;
	localparam int         BLINK_MS        = 500;
	localparam int         BLINK_CYC       = (CLK_HZ / 1000) * BLINK_MS;
	localparam int         TOGGLE_CYC      = CLK_HZ / 16;
	localparam logic [7:0] RESET_BYTE      = 8'h00;
endpackage : eic_pkg
